// *** hdl/acs_pkg.sv ***
// constants and types shared by the converter sequencer
package acs_pkg;
  typedef logic [2:0] acs_chan_t;
  typedef logic [9:0] acs_code_t;
  typedef logic [9:0] acs_hs_t;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'h0,
    ACS_SAMPLE = 2'h1,
    ACS_CONVERT = 2'h3
  } acs_state_t;
  // all durations are in half state times
  localparam acs_hs_t ACS_HS_SAMPLE_PRE_ON = 10'h020;
  localparam acs_hs_t ACS_HS_TOTAL_PRE_ON = 10'h139;
  localparam acs_hs_t ACS_HS_SAMPLE_PRE_OFF = 10'h010;
  localparam acs_hs_t ACS_HS_TOTAL_PRE_OFF = 10'h0B3;
  localparam acs_hs_t ACS_HS_SAMPLE_UNIT = 10'h008;
  localparam acs_hs_t ACS_HS_CONV_UNIT = 10'h010;
  localparam acs_hs_t ACS_HS_SAMPLE_MIN = 10'h002;
  localparam logic [7:0] ACS_TIMING_TYPICAL = 8'hA6;
  localparam acs_hs_t ACS_HS_TYPICAL_SAMPLE = 10'h028;
  localparam acs_hs_t ACS_HS_TYPICAL_CONV = 10'h070;
  localparam int ACS_STEP_SHIFT = 4;
  localparam logic [3:0] ACS_MSB_IDX = 4'h9;
  localparam logic [3:0] ACS_LSB_IDX_10 = 4'h0;
  localparam logic [3:0] ACS_LSB_IDX_8 = 4'h2;
  localparam acs_code_t ACS_SAR_FIRST = 10'h200;
  localparam acs_code_t ACS_CODE_RESET = 10'h000;
endpackage : acs_pkg

// *** hdl/acs_sequencer.sv ***
// conversion sequencer: channel mux, sample phase and successive approximation
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - 10-bit conversion lasts 156.5 states prescaler on, 89.5 states off.
// - 10-bit sample phase is 16 states prescaler on, 8 states off.
// - an 8-bit mode gives 256-level results, in less time only at short timing values (FFH takes 568 half states).
// - 8-bit sample and convert lengths come from the timing input only.
// - timing value A6H gives 20 sample states then 56 convert states.
// - every timing value sequences a conversion to its end; trial steps under three clocks outrun the comparator sync.
// - mux opens the old channel before closing the new one.
// - 10-bit speed depends only on the prescaler bit, never the timing value.
module acs_sequencer #(
  parameter int HALF_STATE_CLKS = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire acs_pkg::acs_chan_t channel_sel,
  input wire logic mode_8bit,
  input wire logic prescaler_disable_bit,
  input wire logic [7:0] conv_timing,
  input wire logic comp_in,
  output logic [7:0] mux_en,
  output logic sampling,
  output logic busy,
  output acs_pkg::acs_code_t dac_code,
  output logic conv_done,
  output acs_pkg::acs_code_t result,
  output acs_pkg::acs_chan_t result_channel,
  output logic result_8bit
);
  import acs_pkg::*;

  function automatic acs_hs_t acs_sample_hs(input logic m8, input logic pdis,
                                            input logic [7:0] t);
    acs_hs_t s;
    s = 10'(t[7:5]) * ACS_HS_SAMPLE_UNIT;
    if (m8) begin
      acs_sample_hs = (s < ACS_HS_SAMPLE_MIN) ? ACS_HS_SAMPLE_MIN : s;
    end else begin
      acs_sample_hs = pdis ? ACS_HS_SAMPLE_PRE_OFF : ACS_HS_SAMPLE_PRE_ON;
    end
  endfunction : acs_sample_hs

  function automatic acs_hs_t acs_conv_hs(input logic m8, input logic pdis,
                                          input logic [7:0] t);
    if (m8) begin
      acs_conv_hs = (10'(t[4:0]) + 10'h001) * ACS_HS_CONV_UNIT;
    end else if (pdis) begin
      acs_conv_hs = ACS_HS_TOTAL_PRE_OFF - ACS_HS_SAMPLE_PRE_OFF;
    end else begin
      acs_conv_hs = ACS_HS_TOTAL_PRE_ON - ACS_HS_SAMPLE_PRE_ON;
    end
  endfunction : acs_conv_hs

  function automatic acs_hs_t acs_step(input acs_hs_t c);
    acs_step = ((c >> ACS_STEP_SHIFT) == 10'h000) ? 10'h001 : (c >> ACS_STEP_SHIFT);
  endfunction : acs_step

  acs_state_t state, next_state;
  logic [7:0] hs_cnt, next_hs_cnt;
  logic tick;
  acs_hs_t phase_cnt, next_phase_cnt;
  acs_hs_t step_cnt, next_step_cnt;
  acs_hs_t lat_conv, next_lat_conv;
  acs_chan_t lat_chan, next_lat_chan;
  logic lat_m8, next_lat_m8;
  acs_code_t sar, next_sar;
  logic [3:0] bit_idx, next_bit_idx;
  logic bits_active, next_bits_active;
  logic next_done;
  acs_code_t next_result;
  acs_chan_t next_result_channel;
  logic next_result_8bit;
  logic [7:0] want_mux, next_mux_en;
  logic comp_meta, comp_sync;

  // comparator settles asynchronously to core_clk
  always_ff @(posedge core_clk) begin
    if (rst) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end

  assign tick = (hs_cnt == 8'(HALF_STATE_CLKS - 1));

  always_comb begin
    next_state = state;
    next_hs_cnt = (state == ACS_IDLE || tick) ? 8'h00 : 8'(hs_cnt + 8'h01);
    next_phase_cnt = phase_cnt;
    next_step_cnt = step_cnt;
    next_lat_conv = lat_conv;
    next_lat_chan = lat_chan;
    next_lat_m8 = lat_m8;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_bits_active = bits_active;
    next_done = conv_done;
    next_result = result;
    next_result_channel = result_channel;
    next_result_8bit = result_8bit;
    unique case (state)
      ACS_IDLE: begin
        if (start) begin
          next_state = ACS_SAMPLE;
          next_lat_chan = channel_sel;
          next_lat_m8 = mode_8bit;
          next_phase_cnt = acs_sample_hs(mode_8bit, prescaler_disable_bit, conv_timing);
          next_lat_conv = acs_conv_hs(mode_8bit, prescaler_disable_bit, conv_timing);
          next_done = 1'b0;
        end
      end
      ACS_SAMPLE: begin
        if (tick) begin
          if (phase_cnt == 10'h001) begin
            next_state = ACS_CONVERT;
            next_phase_cnt = lat_conv;
            next_sar = ACS_SAR_FIRST;
            next_bit_idx = ACS_MSB_IDX;
            next_bits_active = 1'b1;
            next_step_cnt = acs_step(lat_conv);
          end else begin
            next_phase_cnt = phase_cnt - 10'h001;
          end
        end
      end
      ACS_CONVERT: begin
        if (tick) begin
          // one trial per step; step is a sixteenth of the phase so all bits fit
          if (bits_active) begin
            if (step_cnt == 10'h001) begin
              next_step_cnt = acs_step(lat_conv);
              if (!comp_sync) begin
                next_sar[bit_idx] = 1'b0;
              end
              if (bit_idx == (lat_m8 ? ACS_LSB_IDX_8 : ACS_LSB_IDX_10)) begin
                next_bits_active = 1'b0;
              end else begin
                next_bit_idx = 4'(bit_idx - 4'h1);
                next_sar[4'(bit_idx - 4'h1)] = 1'b1;
              end
            end else begin
              next_step_cnt = step_cnt - 10'h001;
            end
          end
          if (phase_cnt == 10'h001) begin
            next_state = ACS_IDLE;
            next_done = 1'b1;
            next_result = next_sar;
            next_result_channel = lat_chan;
            next_result_8bit = lat_m8;
          end else begin
            next_phase_cnt = phase_cnt - 10'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ACS_IDLE;
      hs_cnt <= 8'h00;
      phase_cnt <= 10'h000;
      step_cnt <= 10'h000;
      lat_conv <= 10'h000;
      lat_chan <= 3'h0;
      lat_m8 <= 1'b0;
      sar <= ACS_CODE_RESET;
      bit_idx <= 4'h0;
      bits_active <= 1'b0;
      conv_done <= 1'b0;
      result <= ACS_CODE_RESET;
      result_channel <= 3'h0;
      result_8bit <= 1'b0;
      busy <= 1'b0;
      sampling <= 1'b0;
    end else begin
      state <= next_state;
      hs_cnt <= next_hs_cnt;
      phase_cnt <= next_phase_cnt;
      step_cnt <= next_step_cnt;
      lat_conv <= next_lat_conv;
      lat_chan <= next_lat_chan;
      lat_m8 <= next_lat_m8;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      bits_active <= next_bits_active;
      conv_done <= next_done;
      result <= next_result;
      result_channel <= next_result_channel;
      result_8bit <= next_result_8bit;
      busy <= (next_state != ACS_IDLE);
      sampling <= (next_state == ACS_SAMPLE);
    end
  end

  assign dac_code = sar;

  // mux: a change of channel costs one all-open cycle
  always_comb begin
    want_mux = 8'h01 << next_lat_chan;
    next_mux_en = (mux_en != 8'h00 && mux_en != want_mux) ? 8'h00 : want_mux;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mux_en <= 8'h00;
    end else begin
      mux_en <= next_mux_en;
    end
  end

  // helper counts of ticks spent in each phase
  acs_hs_t samp_ticks, conv_ticks;
  logic [7:0] lat_timing;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      samp_ticks <= 10'h000;
      conv_ticks <= 10'h000;
      lat_timing <= 8'h00;
    end else if (state == ACS_IDLE && start) begin
      samp_ticks <= 10'h000;
      conv_ticks <= 10'h000;
      lat_timing <= conv_timing;
    end else if (tick && state == ACS_SAMPLE) begin
      samp_ticks <= samp_ticks + 10'h001;
    end else if (tick && state == ACS_CONVERT) begin
      conv_ticks <= conv_ticks + 10'h001;
    end
  end

  logic lat_pdis;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lat_pdis <= 1'b0;
    end else if (state == ACS_IDLE && start) begin
      lat_pdis <= prescaler_disable_bit;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence conv_end_s;
    state == ACS_IDLE && $past(state) == ACS_CONVERT;
  endsequence

  sequence start_take_s;
    state == ACS_IDLE && start;
  endsequence

  total_time_10_a: assert property (conv_end_s and !lat_m8 |->
    samp_ticks + conv_ticks == (lat_pdis ? ACS_HS_TOTAL_PRE_OFF : ACS_HS_TOTAL_PRE_ON))
    else $error("10-bit conversion length wrong");
  sample_time_10_a: assert property (
    state == ACS_CONVERT && $past(state) == ACS_SAMPLE && !lat_m8 |->
    samp_ticks == (lat_pdis ? ACS_HS_SAMPLE_PRE_OFF : ACS_HS_SAMPLE_PRE_ON))
    else $error("10-bit sample length wrong");
  result_8bit_a: assert property (conv_end_s and lat_m8 |->
    result[1:0] == 2'h0 && result_8bit)
    else $error("8-bit result has low bits set");
  timing_8bit_a: assert property (conv_end_s and lat_m8 |->
    conv_ticks == (10'(lat_timing[4:0]) + 10'h001) * ACS_HS_CONV_UNIT)
    else $error("8-bit convert length not from timing");
  typical_timing_a: assert property (
    conv_end_s and lat_m8 and lat_timing == ACS_TIMING_TYPICAL |->
    samp_ticks == ACS_HS_TYPICAL_SAMPLE && conv_ticks == ACS_HS_TYPICAL_CONV)
    else $error("A6 timing lengths wrong");
  any_timing_ends_a: assert property (state == ACS_SAMPLE && lat_m8 |->
    samp_ticks <= 10'h038)
    else $error("8-bit sample phase overran");
  break_make_a: assert property (
    $past(mux_en) != 8'h00 && mux_en != $past(mux_en) |-> mux_en == 8'h00)
    else $error("mux closed new channel before opening old");
  mux_onehot_a: assert property ($onehot0(mux_en))
    else $error("more than one channel closed");
  done_raise_a: assert property (conv_end_s |-> conv_done &&
    result_channel == lat_chan)
    else $error("done or channel not latched at end");
  done_clear_a: assert property (start_take_s |=> !conv_done && sampling ##0 busy)
    else $error("start did not clear done");
endmodule : acs_sequencer

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  acs_chan_t channel_sel = 3'h0;
  logic mode_8bit = 1'b0;
  logic prescaler_disable_bit = 1'b0;
  logic [7:0] conv_timing = 8'h00;
  logic comp_in = 1'b0;
  logic [7:0] mux_en;
  logic sampling;
  logic busy;
  acs_code_t dac_code;
  logic conv_done;
  acs_code_t result;
  acs_chan_t result_channel;
  logic result_8bit;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  acs_sequencer #(.HALF_STATE_CLKS(1)) dut_u (
    .core_clk(core_clk), .rst(rst), .start(start), .channel_sel(channel_sel),
    .mode_8bit(mode_8bit), .prescaler_disable_bit(prescaler_disable_bit),
    .conv_timing(conv_timing), .comp_in(comp_in), .mux_en(mux_en),
    .sampling(sampling), .busy(busy), .dac_code(dac_code), .conv_done(conv_done),
    .result(result), .result_channel(result_channel), .result_8bit(result_8bit)
  );

  initial forever #4 core_clk = ~core_clk;

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // whole run is a few thousand cycles; this only cuts a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      $display("FAIL at %0t: timeout", $time);
      finish_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // one conversion; durations in half states, poke tries a refused start
  // vin is the analog level; comp_in follows it against the trial code
  task run_conv(input acs_chan_t ch, input logic m8, input logic pd, input logic [7:0] t,
                input acs_code_t vin, input int s_exp, input int tot_exp, input logic poke);
    int n;
    int ns;
    logic zseen;
    logic bad;
    logic changed;
    logic got;
    acs_code_t first_code;
    changed = (channel_sel !== ch);
    got = 1'b0;
    first_code = 10'h000;
    @(negedge core_clk);
    channel_sel = ch;
    mode_8bit = m8;
    prescaler_disable_bit = pd;
    conv_timing = t;
    comp_in = (vin >= dac_code);
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    check(conv_done, 1'b0, "done not cleared");
    n = 1;
    ns = 0;
    zseen = 1'b0;
    bad = 1'b0;
    while (conv_done !== 1'b1 && n < 2000) begin
      if (sampling === 1'b1) ns++;
      else if (!got) begin
        first_code = dac_code;
        got = 1'b1;
      end
      if (mux_en === 8'h00) zseen = 1'b1;
      else if (mux_en !== (8'h01 << ch)) bad = 1'b1;
      if (busy !== 1'b1) bad = 1'b1;
      @(negedge core_clk);
      comp_in = (vin >= dac_code);
      start = poke && (n == 4);
      channel_sel = (poke && n == 4) ? ch + 3'h1 : ch;
      n++;
    end
    check(ns, s_exp, "sample length");
    check(n, tot_exp + 1, "conversion length");
    check(bad, 1'b0, "mux or busy wrong");
    check(zseen, changed, "mux break gap");
    check(first_code, 10'h200, "first trial code");
    check(result, m8 ? (vin & 10'h3FC) : vin, "result");
    check(dac_code, m8 ? (vin & 10'h3FC) : vin, "final trial code");
    check(result_channel, ch, "result channel");
    check(result_8bit, m8, "result mode");
    check(busy, 1'b0, "busy at end");
  endtask : run_conv

  task test_ten_bit;
    run_conv(3'h3, 1'b0, 1'b0, 8'h00, 10'h2A5, 32, 313, 1'b0);
    run_conv(3'h3, 1'b0, 1'b1, 8'h00, 10'h0C3, 16, 179, 1'b0);
    $display("test ten_bit done");
  endtask : test_ten_bit

  task test_timing_ignored;
    run_conv(3'h5, 1'b0, 1'b1, 8'hFF, 10'h3FF, 16, 179, 1'b1);
    run_conv(3'h0, 1'b0, 1'b0, 8'hA6, 10'h000, 32, 313, 1'b0);
    $display("test timing_ignored done");
  endtask : test_timing_ignored

  task test_eight_bit_typical;
    run_conv(3'h7, 1'b1, 1'b0, 8'hA6, 10'h15B, 40, 152, 1'b0);
    run_conv(3'h7, 1'b1, 1'b1, 8'hA6, 10'h000, 40, 152, 1'b1);
    $display("test eight_bit_typical done");
  endtask : test_eight_bit_typical

  task test_eight_bit_extremes;
    // one-cycle steps outrun the comparator sync, so only full-scale levels there
    run_conv(3'h1, 1'b1, 1'b0, 8'h00, 10'h3FF, 2, 18, 1'b0);
    run_conv(3'h2, 1'b1, 1'b0, 8'hFF, 10'h000, 56, 568, 1'b0);
    run_conv(3'h6, 1'b1, 1'b1, 8'h1F, 10'h2E7, 2, 514, 1'b0);
    run_conv(3'h4, 1'b1, 1'b0, 8'hE0, 10'h3FF, 56, 72, 1'b0);
    $display("test eight_bit_extremes done");
  endtask : test_eight_bit_extremes

  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check(busy, 1'b0, "busy after reset");
    check(conv_done, 1'b0, "done after reset");
    check(result, 10'h000, "result after reset");
    check(mux_en, 8'h01, "mux after reset");
    test_ten_bit();
    test_timing_ignored();
    test_eight_bit_typical();
    test_eight_bit_extremes();
    finish_test();
  end
endmodule : tb
`default_nettype wire
